//--- design/sts_pkg.sv
package sts_pkg;

  localparam int NUM_SLOTS = 28;
  localparam int NUM_GPIO = 10;
  localparam int NUM_RAILS = 4;
  localparam int SRC_W = 6;
  localparam int ID_W = 5;

  // Trigger source numbers seen by each slot multiplexer
  localparam logic [5:0] SRC_IMM_SHUTDOWN = 6'h00;
  localparam logic [5:0] SRC_MCU_PWR_ERR = 6'h01;
  localparam logic [5:0] SRC_GRACEFUL_POWEROFF = 6'h02;
  localparam logic [5:0] SRC_FORCE_STANDBY = 6'h03;
  localparam logic [5:0] SRC_LINK_SELFTEST = 6'h04;
  localparam logic [5:0] SRC_ERR_MON_FAULT = 6'h05;
  localparam logic [5:0] SRC_WDOG_FAULT = 6'h06;
  localparam logic [5:0] SRC_SOC_PWR_ERR = 6'h07;
  localparam logic [5:0] SRC_SLEEP_11 = 6'h08;
  localparam logic [5:0] SRC_WAKE_FIRST = 6'h09;
  localparam logic [5:0] SRC_STARTUP_FULL = 6'h0A;
  localparam logic [5:0] SRC_SLEEP_10 = 6'h0B;
  localparam logic [5:0] SRC_WAKE_SECOND = 6'h0C;
  localparam logic [5:0] SRC_STARTUP_CTRL = 6'h0D;
  localparam logic [5:0] SRC_SLEEP_01 = 6'h0E;
  localparam logic [5:0] SRC_SLEEP_00 = 6'h0F;
  localparam logic [5:0] SRC_STARTUP_LOWPWR = 6'h10;
  localparam logic [5:0] SRC_STARTUP_USER = 6'h11;
  localparam logic [5:0] SRC_WAIT_TIMEOUT = 6'h12;
  localparam logic [5:0] SRC_GPIO_BASE = 6'h13;
  localparam logic [5:0] SRC_SWTRIG_BASE = 6'h1D;
  localparam logic [5:0] SRC_SCRATCH_BASE = 6'h25;
  localparam logic [5:0] SRC_CONST0 = 6'h2D;
  localparam logic [5:0] SRC_CONST1 = 6'h2E;

  // Detector types
  localparam logic [1:0] TYPE_HIGH = 2'h0;
  localparam logic [1:0] TYPE_LOW = 2'h1;
  localparam logic [1:0] TYPE_RISE = 2'h2;
  localparam logic [1:0] TYPE_FALL = 2'h3;

  // Field codes
  localparam logic [1:0] SLEEP_CODE_A = 2'h3;
  localparam logic [1:0] SLEEP_CODE_B = 2'h2;
  localparam logic [1:0] SLEEP_CODE_C = 2'h1;
  localparam logic [1:0] SLEEP_CODE_D = 2'h0;
  localparam logic [1:0] DEST_FULL = 2'h3;
  localparam logic [1:0] DEST_CTRL = 2'h2;
  localparam logic [1:0] DEST_LOWPWR = 2'h0;
  localparam logic [1:0] DEST_USER = 2'h1;
  localparam logic [1:0] GRP_MCU = 2'h1;
  localparam logic [1:0] GRP_SOC = 2'h2;
  localparam logic [1:0] PIN_FUNC_BUTTON = 2'h1;
  localparam logic [1:0] PIN_FUNC_ENABLE = 2'h0;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STAGED = 8'h08;
  localparam logic [7:0] ADDR_SWTRIG = 8'h0C;
  localparam logic [7:0] ADDR_SCRATCH = 8'h10;
  localparam logic [7:0] ADDR_SETUP = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PENDING = 8'h1C;
  localparam logic [7:0] ADDR_SLOT_BASE = 8'h40;

  // Field positions
  localparam int SETUP_DEST_LSB = 0;
  localparam int SETUP_PINF_LSB = 2;
  localparam int SETUP_WAKE1_LSB = 4;
  localparam int SETUP_WAKE2_LSB = 8;
  localparam int SETUP_GRP_LSB = 12;
  localparam int SETUP_W = 20;
  localparam int SLOT_TYPE_LSB = 6;
  localparam int SLOT_IMM_BIT = 8;
  localparam int SLOT_W = 9;

  // Reset values
  localparam logic [27:0] MASK_RST = 28'hFFFFFFF;
  localparam logic [8:0] SLOT_RST = 9'h02D;
  localparam logic [19:0] SETUP_RST = 20'h00000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIXED} sts_state_e;

endpackage : sts_pkg

//--- design/sts_trigger_select.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sts_trigger_select #(
  parameter int NUM_SLOTS = sts_pkg::NUM_SLOTS,
  parameter int NUM_GPIO = sts_pkg::NUM_GPIO,
  parameter int NUM_RAILS = sts_pkg::NUM_RAILS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins from the host side
  input wire logic [NUM_GPIO-1:0] gpio_pin,
  input wire logic sleep_request_pin_first,
  input wire logic sleep_request_pin_second,
  input wire logic enable_pin,
  // Device events, one-cycle pulses unless stated
  input wire logic imm_shutdown_event,
  input wire logic imm_shutdown_action,
  input wire logic [NUM_RAILS-1:0] rail_output_fail,
  input wire logic medium_severity_fault_flag_set,
  input wire logic power_button_pin_long_press,
  input wire logic error_monitor_reset_flag_set,
  input wire logic watchdog_reset_flag_set,
  input wire logic link_watchdog_selftest_finished,
  input wire logic on_request_valid,
  input wire logic wait_timeout,
  input wire logic fixed_state_event,
  // Sequencer engine
  input wire logic seq_mask_valid,
  input wire logic [NUM_SLOTS-1:0] seq_mask_value,
  input wire logic seq_end,
  output logic seq_start,
  output logic seq_abort,
  output logic [sts_pkg::ID_W-1:0] seq_id,
  output logic seq_imm,
  output logic fixed_state_machine_takeover,
  output logic [NUM_SLOTS-1:0] active_mask
);
  import sts_pkg::*;

  typedef struct packed {
    logic [NUM_GPIO-1:0] gpio_s1;
    logic [NUM_GPIO-1:0] gpio_s2;
    logic [NUM_GPIO-1:0] gpio_prev;
    logic [1:0] sleep_s1;
    logic [1:0] sleep_s2;
    logic en_s1;
    logic en_s2;
    logic [NUM_SLOTS-1:0][SLOT_W-1:0] slot_cfg;
    logic [NUM_SLOTS-1:0] mask;
    logic [NUM_SLOTS-1:0] staged;
    logic staged_valid;
    logic [7:0] swtrig;
    logic [7:0] scratch;
    logic [SETUP_W-1:0] setup;
    logic run_en;
    logic [NUM_SLOTS-1:0] src_prev;
    logic [NUM_SLOTS-1:0] edge_pend;
    sts_state_e st;
    logic [ID_W-1:0] cur_id;
    logic start;
    logic abort;
    logic [ID_W-1:0] id;
    logic imm;
    logic takeover;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sts_state_s;

  sts_state_s state_reg;
  sts_state_s state_next;

  function automatic logic [31:0] sts_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : sts_merge

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sts_state_s n;
    logic [63:0] src;
    logic [NUM_GPIO-1:0] gpio_edge;
    logic [1:0] sleep_code;
    logic [1:0] dest;
    logic [1:0] pinf;
    logic [3:0] wk1;
    logic [3:0] wk2;
    logic mcu_err;
    logic soc_err;
    logic s;
    logic [NUM_SLOTS-1:0] live;
    logic [NUM_SLOTS-1:0] edges;
    logic [NUM_SLOTS-1:0] enabled;
    logic [NUM_SLOTS-1:0] imm_vec;
    logic [NUM_SLOTS-1:0] clr;
    logic [ID_W-1:0] pick;
    logic [ID_W-1:0] pick_imm;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [7:0] slot_idx;
    logic rd_ok;
    logic wr_ok;
    n = state_reg;
    src = '0;
    live = '0;
    edges = '0;
    clr = '0;
    pick = '0;
    pick_imm = '0;
    rd = '0;
    wv = '0;
    slot_idx = '0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    mcu_err = 1'b0;
    soc_err = 1'b0;
    s = 1'b0;

    // Two-stage synchronisers; only stage two is ever looked at
    n.gpio_s1 = gpio_pin;
    n.gpio_s2 = state_reg.gpio_s1;
    n.gpio_prev = state_reg.gpio_s2;
    n.sleep_s1 = {sleep_request_pin_second, sleep_request_pin_first};
    n.sleep_s2 = state_reg.sleep_s1;
    n.en_s1 = enable_pin;
    n.en_s2 = state_reg.en_s1;

    gpio_edge = state_reg.gpio_s2 ^ state_reg.gpio_prev;
    sleep_code = state_reg.sleep_s2;
    dest = state_reg.setup[SETUP_DEST_LSB +: 2];
    pinf = state_reg.setup[SETUP_PINF_LSB +: 2];
    wk1 = state_reg.setup[SETUP_WAKE1_LSB +: 4];
    wk2 = state_reg.setup[SETUP_WAKE2_LSB +: 4];
    for (int r = 0; r < NUM_RAILS; r++) begin
      mcu_err |= rail_output_fail[r] && state_reg.setup[SETUP_GRP_LSB + 2*r +: 2] == GRP_MCU;
      soc_err |= rail_output_fail[r] && state_reg.setup[SETUP_GRP_LSB + 2*r +: 2] == GRP_SOC;
    end

    ////////////////////////////////////////////////////////////////////////
    // Source bus
    src[SRC_IMM_SHUTDOWN] = imm_shutdown_event & imm_shutdown_action;
    src[SRC_MCU_PWR_ERR] = mcu_err;
    src[SRC_SOC_PWR_ERR] = soc_err;
    src[SRC_GRACEFUL_POWEROFF] = medium_severity_fault_flag_set;
    src[SRC_FORCE_STANDBY] = (power_button_pin_long_press && pinf == PIN_FUNC_BUTTON) ||
                             (!state_reg.en_s2 && pinf == PIN_FUNC_ENABLE);
    src[SRC_LINK_SELFTEST] = link_watchdog_selftest_finished;
    src[SRC_ERR_MON_FAULT] = error_monitor_reset_flag_set;
    src[SRC_WDOG_FAULT] = watchdog_reset_flag_set;
    src[SRC_SLEEP_11] = sleep_code == SLEEP_CODE_A;
    src[SRC_SLEEP_10] = sleep_code == SLEEP_CODE_B;
    src[SRC_SLEEP_01] = sleep_code == SLEEP_CODE_C;
    src[SRC_SLEEP_00] = sleep_code == SLEEP_CODE_D;
    // Out-of-range pin index simply never fires
    src[SRC_WAKE_FIRST] = (32'(wk1) < NUM_GPIO) && gpio_edge[wk1];
    src[SRC_WAKE_SECOND] = (32'(wk2) < NUM_GPIO) && gpio_edge[wk2];
    src[SRC_STARTUP_FULL] = on_request_valid && dest == DEST_FULL;
    src[SRC_STARTUP_CTRL] = on_request_valid && dest == DEST_CTRL;
    src[SRC_STARTUP_LOWPWR] = on_request_valid && dest == DEST_LOWPWR;
    src[SRC_STARTUP_USER] = on_request_valid && dest == DEST_USER;
    src[SRC_WAIT_TIMEOUT] = wait_timeout;
    for (int g = 0; g < NUM_GPIO; g++) begin
      src[32'(SRC_GPIO_BASE) + g] = state_reg.gpio_s2[g];
    end
    for (int b = 0; b < 8; b++) begin
      src[32'(SRC_SWTRIG_BASE) + b] = state_reg.swtrig[b];
      src[32'(SRC_SCRATCH_BASE) + b] = state_reg.scratch[b];
    end
    src[SRC_CONST0] = 1'b0;
    src[SRC_CONST1] = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Per-slot mux and detector
    for (int i = 0; i < NUM_SLOTS; i++) begin
      s = src[state_reg.slot_cfg[i][SRC_W-1:0]];
      n.src_prev[i] = s;
      case (state_reg.slot_cfg[i][SLOT_TYPE_LSB +: 2])
        TYPE_HIGH: live[i] = s;
        TYPE_LOW: live[i] = !s;
        TYPE_RISE: edges[i] = s && !state_reg.src_prev[i];
        TYPE_FALL: edges[i] = !s && state_reg.src_prev[i];
        default: live[i] = 1'b0;
      endcase
    end

    enabled = (live | state_reg.edge_pend) & ~state_reg.mask;
    imm_vec = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      imm_vec[i] = enabled[i] && state_reg.slot_cfg[i][SLOT_IMM_BIT] &&
                   !(state_reg.st == ST_RUN && ID_W'(i) == state_reg.cur_id);
    end
    // Downward scan leaves the lowest number standing
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        pick = ID_W'(i);
      end
      if (imm_vec[i]) begin
        pick_imm = ID_W'(i);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine control
    n.start = 1'b0;
    n.abort = 1'b0;
    if (seq_mask_valid) begin
      n.staged = seq_mask_value;
      n.staged_valid = 1'b1;
    end
    case (state_reg.st)
      ST_IDLE: begin
        if (state_reg.takeover) begin
          n.st = ST_FIXED;
        end else if (seq_end) begin
          // Start-up section ends with a terminator too; otherwise the reset mask could never open
          if (seq_mask_valid || state_reg.staged_valid) begin
            n.mask = seq_mask_valid ? seq_mask_value : state_reg.staged;
          end
          n.staged_valid = 1'b0;
        end else if (state_reg.run_en && |enabled) begin
          n.start = 1'b1;
          n.id = pick;
          n.imm = state_reg.slot_cfg[pick][SLOT_IMM_BIT];
          n.cur_id = pick;
          clr[pick] = 1'b1;
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (state_reg.takeover) begin
          n.st = ST_FIXED;
        end else if (seq_end) begin
          // Mask only moves at the terminator; same-cycle mask command counts
          if (seq_mask_valid || state_reg.staged_valid) begin
            n.mask = seq_mask_valid ? seq_mask_value : state_reg.staged;
          end
          n.staged_valid = 1'b0;
          n.st = ST_IDLE;
        end else if (|imm_vec) begin
          n.abort = 1'b1;
          n.start = 1'b1;
          n.id = pick_imm;
          n.imm = 1'b1;
          n.cur_id = pick_imm;
          clr[pick_imm] = 1'b1;
          n.staged_valid = 1'b0;
        end
      end
      ST_FIXED: begin
        n.staged_valid = 1'b0;
        if (!state_reg.takeover) begin
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // New edge in the serving cycle is kept
    n.edge_pend = (state_reg.edge_pend & ~clr) | edges;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write
    if (s_axi_awvalid && state_reg.awready) begin
      n.aw_hold = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      n.w_hold = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (state_reg.aw_hold && state_reg.w_hold && !state_reg.bvalid) begin
      wr_ok = 1'b1;
      case (state_reg.aw_addr & 8'hFC)
        ADDR_CTRL: begin
          wv = sts_merge({31'h0, state_reg.run_en}, state_reg.w_data, state_reg.w_strb);
          n.run_en = wv[0];
          if (wv[0]) begin
            n.takeover = 1'b0;
          end
        end
        ADDR_SWTRIG: begin
          wv = sts_merge({24'h0, state_reg.swtrig}, state_reg.w_data, state_reg.w_strb);
          n.swtrig = wv[7:0];
        end
        ADDR_SCRATCH: begin
          wv = sts_merge({24'h0, state_reg.scratch}, state_reg.w_data, state_reg.w_strb);
          n.scratch = wv[7:0];
        end
        ADDR_SETUP: begin
          wv = sts_merge({12'h0, state_reg.setup}, state_reg.w_data, state_reg.w_strb);
          n.setup = wv[SETUP_W-1:0];
        end
        ADDR_MASK, ADDR_STAGED, ADDR_STATUS, ADDR_PENDING: wr_ok = 1'b1;
        default: begin
          slot_idx = (state_reg.aw_addr - ADDR_SLOT_BASE) >> 2;
          if (state_reg.aw_addr >= ADDR_SLOT_BASE && 32'(slot_idx) < NUM_SLOTS) begin
            wv = sts_merge({23'h0, state_reg.slot_cfg[slot_idx[ID_W-1:0]]}, state_reg.w_data, state_reg.w_strb);
            n.slot_cfg[slot_idx[ID_W-1:0]] = wv[SLOT_W-1:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
      endcase
      n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      n.bvalid = 1'b1;
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
    end
    // Hardware takeover beats a software release in the same cycle
    if (fixed_state_event) begin
      n.takeover = 1'b1;
      n.run_en = 1'b0;
    end
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready = !n.w_hold && !n.bvalid;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    if (state_reg.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      rd_ok = 1'b1;
      case (s_axi_araddr & 8'hFC)
        ADDR_CTRL: rd = {31'h0, state_reg.run_en};
        ADDR_MASK: rd = {4'h0, state_reg.mask};
        ADDR_STAGED: rd = {3'h0, state_reg.staged_valid, state_reg.staged};
        ADDR_SWTRIG: rd = {24'h0, state_reg.swtrig};
        ADDR_SCRATCH: rd = {24'h0, state_reg.scratch};
        ADDR_SETUP: rd = {12'h0, state_reg.setup};
        ADDR_STATUS: rd = {24'h0, state_reg.takeover, state_reg.st, state_reg.cur_id};
        ADDR_PENDING: rd = {4'h0, enabled};
        default: begin
          slot_idx = (s_axi_araddr - ADDR_SLOT_BASE) >> 2;
          if (s_axi_araddr >= ADDR_SLOT_BASE && 32'(slot_idx) < NUM_SLOTS) begin
            rd = {23'h0, state_reg.slot_cfg[slot_idx[ID_W-1:0]]};
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
      n.rdata = rd;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      n.rvalid = 1'b1;
    end
    n.arready = !n.rvalid;

    if (!aresetn) begin
      n = '0;
      n.st = ST_IDLE;
      n.mask = MASK_RST;
      n.setup = SETUP_RST;
      n.slot_cfg = {NUM_SLOTS{SLOT_RST}};
      n.en_s1 = 1'b1;
      n.en_s2 = 1'b1;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.arready = 1'b1;
    end
    state_next = n;
  end

  always_ff @(posedge aclk) begin
    state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign seq_start = state_reg.start;
  assign seq_abort = state_reg.abort;
  assign seq_id = state_reg.id;
  assign seq_imm = state_reg.imm;
  assign fixed_state_machine_takeover = state_reg.takeover;
  assign active_mask = state_reg.mask;

endmodule : sts_trigger_select
`default_nettype wire

//--- test/sts_trigger_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sts_trigger_select_checker #(
  parameter int NUM_SLOTS = 28
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Engine side
  input wire logic fixed_state_event,
  input wire logic seq_mask_valid,
  input wire logic [NUM_SLOTS-1:0] seq_mask_value,
  input wire logic seq_end,
  input wire logic seq_start,
  input wire logic seq_abort,
  input wire logic seq_imm,
  input wire logic fixed_state_machine_takeover,
  input wire logic [NUM_SLOTS-1:0] active_mask
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Stray ends outside a sequence are not judged
  logic run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || fixed_state_event || seq_end) begin
      run_q <= 1'h0;
    end else if (seq_start) begin
      run_q <= 1'h1;
    end
  end
  sequence s_end_cmd;
    run_q && seq_end && seq_mask_valid && !fixed_state_event;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_mask_hold;
    !seq_end |=> $stable(active_mask);
  endproperty
  property p_mask_apply;
    s_end_cmd |=> active_mask == $past(seq_mask_value);
  endproperty
  property p_abort_start;
    seq_abort |-> seq_start;
  endproperty
  property p_abort_imm;
    seq_abort |-> seq_imm;
  endproperty
  property p_take;
    fixed_state_event |=> fixed_state_machine_takeover;
  endproperty
  property p_no_start;
    fixed_state_machine_takeover |=> !seq_start;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask moved without end");
  a_mask_apply: assert property (p_mask_apply) else $error("mask not applied");
  a_abort_start: assert property (p_abort_start) else $error("abort alone");
  a_abort_imm: assert property (p_abort_imm) else $error("abort by plain slot");
  a_take: assert property (p_take) else $error("no takeover");
  a_no_start: assert property (p_no_start) else $error("start under takeover");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
endmodule : sts_trigger_select_checker
bind sts_trigger_select sts_trigger_select_checker #(.NUM_SLOTS(NUM_SLOTS)) chk_u (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .fixed_state_event, .seq_mask_valid, .seq_mask_value, .seq_end, .seq_start, .seq_abort, .seq_imm,
  .fixed_state_machine_takeover, .active_mask);
`default_nettype wire

//--- test/sts_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sts_host_model #(
  parameter int LAG = 1
) (
  // Clock and bench requests
  input wire logic aclk,
  input wire logic [1:0] code_cmd,
  input wire logic [9:0] gpio_cmd,
  input wire logic en_cmd,
  // Pins toward the block
  output logic sleep_request_pin_first,
  output logic sleep_request_pin_second,
  output logic [9:0] gpio_pin,
  output logic enable_pin
);
  // LAG+1 edges of delay model a slow host
  logic [11:0] pipe [LAG+1] = '{default: 12'hC00};
  always @(posedge aclk) begin
    pipe[0] <= {code_cmd, gpio_cmd};
    for (int i = 1; i <= LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign {sleep_request_pin_second, sleep_request_pin_first} = pipe[LAG][11:10];
  assign gpio_pin = pipe[LAG][9:0];
  // Enable level is slow, so no pipeline
  assign enable_pin = en_cmd;
endmodule : sts_host_model
`default_nettype wire

//--- test/sts_trigger_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sts_trigger_select_tb;
  import sts_pkg::*;
  localparam logic [5:0] SRCS [16] = '{SRC_IMM_SHUTDOWN, SRC_MCU_PWR_ERR, SRC_SOC_PWR_ERR, SRC_GRACEFUL_POWEROFF,
    SRC_LINK_SELFTEST, SRC_ERR_MON_FAULT, SRC_WDOG_FAULT, SRC_STARTUP_LOWPWR, SRC_WAIT_TIMEOUT, SRC_FORCE_STANDBY,
    SRC_SLEEP_00, SRC_SLEEP_01, SRC_SLEEP_10, SRC_SLEEP_11, SRC_GPIO_BASE + 6'h04, SRC_WAKE_FIRST};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sab;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, code = 2'h3;
  logic [9:0] gpio_pin, ev = 10'h000, gpio = 10'h000;
  logic sleep_request_pin_first, sleep_request_pin_second, enable_pin;
  logic fixed_state_event = 1'h0, seq_mask_valid = 1'h0, seq_end = 1'h0, en = 1'h1;
  logic [27:0] seq_mask_value = 28'h0, active_mask;
  logic seq_start, seq_abort, seq_imm, fixed_state_machine_takeover;
  logic [4:0] seq_id, sid;
  int fails, check_count, starts, seen;
  sts_trigger_select dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_pin,
    .sleep_request_pin_first, .sleep_request_pin_second, .enable_pin, .imm_shutdown_event(ev[0]),
    .imm_shutdown_action(ev[0]), .rail_output_fail({2'h0, ev[2:1]}), .medium_severity_fault_flag_set(ev[3]),
    .link_watchdog_selftest_finished(ev[4]), .error_monitor_reset_flag_set(ev[5]), .watchdog_reset_flag_set(ev[6]),
    .on_request_valid(ev[7]), .wait_timeout(ev[8]), .power_button_pin_long_press(ev[9]), .fixed_state_event,
    .seq_mask_valid, .seq_mask_value, .seq_end, .seq_start, .seq_abort, .seq_id, .seq_imm,
    .fixed_state_machine_takeover, .active_mask);
  sts_host_model #(.LAG(2)) host_u (.aclk, .code_cmd(code), .gpio_cmd(gpio), .sleep_request_pin_first,
    .sleep_request_pin_second, .gpio_pin, .enable_pin, .en_cmd(en));
  always #50 aclk = ~aclk;
  // Starts are pulses, so record them as they pass
  always @(posedge aclk) begin
    if (seq_start === 1'h1) begin
      starts = starts + 1;
      sid = seq_id;
      sab = seq_abort;
    end
  end
  task automatic conclude;
    $display("mismatches %0d in %0d checks", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Requests just scheduled are not visible yet, so test after the edge
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
      end
    end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
      end
    end while (s_axi_arvalid | s_axi_rready);
  endtask : rd
  task automatic slot(input int i, input logic [8:0] v);
    wr(ADDR_SLOT_BASE + 8'(4 * i), 32'(v));
  endtask : slot
  // Mask command issued together with the terminator
  task automatic fin(input logic [27:0] m);
    @(posedge aclk);
    seq_mask_valid <= 1'h1;
    seq_mask_value <= m;
    seq_end <= 1'h1;
    @(posedge aclk);
    seq_mask_valid <= 1'h0;
    seq_end <= 1'h0;
    #1 chk(active_mask, m);
  endtask : fin
  task automatic exp_id(input int id, input logic ab);
    wait (starts != seen);
    seen = starts;
    chk(sid, id);
    chk(sab, ab);
  endtask : exp_id
  initial begin
    repeat (6000) @(posedge aclk);
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_MASK);
    chk(rdat, 32'(MASK_RST));
    rd(ADDR_SLOT_BASE + 8'h14);
    chk(rdat, 32'(SLOT_RST));
    rd(8'h3C);
    chk({rdat[29:0], resp}, 32'(RESP_SLVERR));
    wr(8'h20, 32'h1);
    chk(resp, RESP_SLVERR);
    slot(0, {3'h0, SRC_CONST1});
    wr(ADDR_SETUP, 32'h09004);
    wr(ADDR_CTRL, 32'h1);
    fin(28'hFFFFFFE);
    exp_id(0, 1'h0);
    slot(1, {3'h0, SRC_SWTRIG_BASE});
    slot(2, {3'h0, SRC_SCRATCH_BASE});
    wr(ADDR_SWTRIG, 32'h1);
    wr(ADDR_SCRATCH, 32'h1);
    @(posedge aclk) seq_mask_valid <= 1'h1;
    @(posedge aclk) seq_mask_valid <= 1'h0;
    #1 chk(active_mask, 28'hFFFFFFE);
    fin(28'hFFFFFF9);
    exp_id(1, 1'h0);
    fin(28'hFFFFFFB);
    exp_id(2, 1'h0);
    slot(0, {1'h1, TYPE_HIGH, SRC_SWTRIG_BASE + 6'h01});
    slot(3, {3'h0, SRC_CONST1});
    fin(28'hFFFFFF6);
    exp_id(3, 1'h0);
    wr(ADDR_SWTRIG, 32'h2);
    exp_id(0, 1'h1);
    chk(seq_imm, 1'h1);
    wr(ADDR_SWTRIG, 32'h0);
    for (int k = 0; k < 16; k++) begin
      slot(3, {1'h0, (k == 15) ? TYPE_RISE : TYPE_HIGH, SRCS[k]});
      fin(28'hFFFFFF7);
      repeat (4) @(posedge aclk);
      chk(starts, seen);
      ev <= (k < 10) ? 10'(1 << k) : 10'h000;
      gpio <= (k == 14) ? 10'h010 : (k == 15) ? 10'h011 : 10'h000;
      if (k > 9 && k < 14) code <= 2'(k - 10);
      @(posedge aclk) ev <= 10'h000;
      exp_id(3, 1'h0);
    end
    // Enable-pin path of forced standby, pin function 00
    wr(ADDR_SETUP, 32'h09000);
    slot(3, {3'h0, SRC_FORCE_STANDBY});
    fin(28'hFFFFFF7);
    @(posedge aclk) en <= 1'h0;
    exp_id(3, 1'h0);
    @(posedge aclk) fixed_state_event <= 1'h1;
    @(posedge aclk) fixed_state_event <= 1'h0;
    #1 chk(fixed_state_machine_takeover, 1'h1);
    repeat (10) @(posedge aclk);
    chk(starts, seen);
    conclude();
  end
endmodule : sts_trigger_select_tb
`default_nettype wire
